// ===== core/backup_power_supervisor.v
// Purpose: Switches between main supply and backup battery, stamps
//          switchovers and reports supply and battery status
// Assumes: Comparator inputs come from analog blocks, asynchronous
// Notes:   Registers reached over Avalon-MM with waitrequest
//
// Behaviour
// - Enter backup only when both conditions hold
// - Leave backup when either return condition holds
// - Serial bus disabled in backup, timekeeping continues
// - Other pins stay active unless control disables
// - Stamp each switchover; first down, latest up
// - Stamps held until stamp-clear written as one
// - Compensation in backup only with backup-sensing enable
// - Flag power-up after total supply loss
// - Brownout flag from one of six levels
// - Brownout alone never disables the serial bus
// - Below 85% first flag, below 75% both
// - No battery measurement while in backup mode
`include "supervisor_map.vh"

module backup_power_supervisor (
    // Clock and reset
    input  wire                        i_mclk,
    input  wire                        i_sys_rst,
    // Avalon-MM slave
    input  wire [5:0]                  i_address,
    input  wire                        i_read,
    input  wire                        i_write,
    input  wire [31:0]                 i_writedata,
    output wire [31:0]                 o_readdata,
    output wire                        o_waitrequest,
    // Supply comparators
    input  wire                        i_vdd_below_bat_hys,
    input  wire                        i_vdd_below_trip,
    input  wire                        i_vdd_above_bat_hys,
    input  wire                        i_vdd_above_trip_hys,
    input  wire [`BROWNOUT_LEVELS-1:0] i_vdd_below_level,
    // Battery comparators
    input  wire                        i_bat_below_85,
    input  wire                        i_bat_below_75,
    // Power-up after total loss, level from the power-on circuit
    input  wire                        i_cold_start,
    // Current time and date
    input  wire [`STAMP_WIDTH-1:0]     i_time_date,
    // Serial host bus gating
    input  wire                        i_scl,
    input  wire                        i_sda,
    output wire                        o_scl_gated,
    output wire                        o_sda_gated,
    output wire                        o_serial_enable,
    // Supply and side functions
    output wire                        o_battery_mode,
    output wire                        o_aux_io_enable,
    output wire                        o_compensation_run,
    output wire                        o_measure_pulse,
    // Interrupt
    output wire                        o_irq
);

    // Mode states, one-hot
    localparam [1:0] ST_NORMAL = 2'b01;
    localparam [1:0] ST_BACKUP = 2'b10;

    // Synchronised comparator levels
    wire [3:0]                  sw_sync;
    wire [`BROWNOUT_LEVELS-1:0] lvl_sync;
    wire [1:0]                  bat_sync;
    wire                        below_bat_hys;
    wire                        below_trip;
    wire                        above_bat_hys;
    wire                        above_trip_hys;

    // Mode and events
    reg  [1:0]                  mode_reg;
    reg  [1:0]                  mode_next;
    wire                        in_backup;
    wire                        go_backup;
    wire                        go_normal;

    // Bus slave
    reg                         waitrequest_reg;
    reg  [31:0]                 readdata_reg;
    reg  [31:0]                 rd_mux;
    wire                        req;
    wire                        wr_ok;

    // Software registers
    reg  [`ST_WIDTH-1:0]        status_reg;
    reg  [`ST_WIDTH-1:0]        status_next;
    reg  [`ST_WIDTH-1:0]        mask_reg;
    reg  [2:0]                  sel_reg;
    reg                         backup_sense_reg;
    reg                         aux_enable_reg;
    reg                         stamp_clear_reg;
    reg                         measure_reg;
    reg                         cold_armed_reg;
    reg                         irq_reg;
    wire                        wr_status;
    wire                        wr_control;

    // Gated outputs
    reg                         scl_gated_reg;
    reg                         sda_gated_reg;
    reg                         serial_enable_reg;
    reg                         battery_mode_reg;
    reg                         aux_io_enable_reg;
    reg                         comp_run_reg;

    // Stamps
    wire [`STAMP_WIDTH-1:0]     tobat_stamp;
    wire [`STAMP_WIDTH-1:0]     tosup_stamp;
    wire                        tobat_valid;
    wire                        tosup_valid;

    // Selected brownout level, out-of-range select reads as no brownout
    function sel_level;
        input [`BROWNOUT_LEVELS-1:0] lv;
        input [2:0]                  sel;
        begin
            if (sel < 3'h6) begin
                sel_level = lv[sel];
            end else begin
                sel_level = 1'b0;
            end
        end
    endfunction

    // Upper word of a stamp, zero extended
    function [31:0] stamp_hi;
        input [`STAMP_WIDTH-1:0] s;
        begin
            stamp_hi = {{(64 - `STAMP_WIDTH){1'b0}}, s[`STAMP_WIDTH-1:32]};
        end
    endfunction

    // Comparators cross into the clock domain here
    level_sync #(
        .WIDTH (4)
    ) u_sw_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_level   ({i_vdd_below_bat_hys, i_vdd_below_trip,
                     i_vdd_above_bat_hys, i_vdd_above_trip_hys}),
        .o_level   (sw_sync)
    );

    level_sync #(
        .WIDTH (`BROWNOUT_LEVELS + 2)
    ) u_lvl_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_level   ({i_bat_below_75, i_bat_below_85, i_vdd_below_level}),
        .o_level   ({bat_sync, lvl_sync})
    );

    assign below_bat_hys  = sw_sync[3];
    assign below_trip     = sw_sync[2];
    assign above_bat_hys  = sw_sync[1];
    assign above_trip_hys = sw_sync[0];

    // Mode decisions
    assign in_backup = mode_reg[1];
    assign go_backup = mode_reg[0] && below_bat_hys && below_trip;
    assign go_normal = mode_reg[1] && (above_bat_hys || above_trip_hys);

    // Mode next state
    always @* begin
        case (mode_reg)
            ST_NORMAL: begin
                mode_next = go_backup ? ST_BACKUP : ST_NORMAL;
            end
            ST_BACKUP: begin
                mode_next = go_normal ? ST_NORMAL : ST_BACKUP;
            end
            default: begin
                mode_next = ST_NORMAL;
            end
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mode_reg <= ST_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Bus handshake: one wait cycle, then one ready cycle
    assign req   = i_read || i_write;
    assign wr_ok = i_write && !waitrequest_reg;
    assign wr_status  = wr_ok && (i_address == `OFS_STATUS);
    assign wr_control = wr_ok && (i_address == `OFS_CONTROL);

    // Read mux; unmapped offsets read zero
    always @* begin
        rd_mux = 32'h00000000;
        case (i_address)
            `OFS_STATUS:   rd_mux[`ST_WIDTH-1:0] = status_reg;
            `OFS_MASK:     rd_mux[`ST_WIDTH-1:0] = mask_reg;
            `OFS_CONTROL: begin
                rd_mux[`CT_BACKUP_SENSE]              = backup_sense_reg;
                rd_mux[`CT_SEL_MSB:`CT_SEL_LSB]       = sel_reg;
                rd_mux[`CT_AUX_ENABLE]                = aux_enable_reg;
            end
            `OFS_MODE: begin
                rd_mux[0] = in_backup;
                rd_mux[1] = tobat_valid;
                rd_mux[2] = tosup_valid;
            end
            `OFS_TOBAT_LO: rd_mux = tobat_stamp[31:0];
            `OFS_TOBAT_HI: rd_mux = stamp_hi(tobat_stamp);
            `OFS_TOSUP_LO: rd_mux = tosup_stamp[31:0];
            `OFS_TOSUP_HI: rd_mux = stamp_hi(tosup_stamp);
            default:       rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            waitrequest_reg <= 1'b1;
            readdata_reg    <= 32'h00000000;
        end else if (req && waitrequest_reg) begin
            waitrequest_reg <= 1'b0;
            readdata_reg    <= rd_mux;
        end else begin
            waitrequest_reg <= 1'b1;
        end
    end

    // Control register; sense and clear bits are write pulses
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mask_reg         <= `RST_MASK;
            sel_reg          <= `RST_SEL;
            backup_sense_reg <= `RST_BACKUP_SENSE;
            aux_enable_reg   <= `RST_AUX_ENABLE;
            stamp_clear_reg  <= 1'b0;
            measure_reg      <= 1'b0;
        end else begin
            if (wr_ok && (i_address == `OFS_MASK)) begin
                mask_reg <= i_writedata[`ST_WIDTH-1:0];
            end
            if (wr_control) begin
                sel_reg          <= i_writedata[`CT_SEL_MSB:`CT_SEL_LSB];
                backup_sense_reg <= i_writedata[`CT_BACKUP_SENSE];
                aux_enable_reg   <= i_writedata[`CT_AUX_ENABLE];
            end
            stamp_clear_reg <= wr_control && i_writedata[`CT_STAMP_CLEAR];
            // Measurement only outside backup mode
            measure_reg <= wr_control && i_writedata[`CT_SENSE] && !in_backup;
        end
    end

    // Stamp registers per direction
    switch_stamp #(
        .KEEP_FIRST (1)
    ) u_tobat (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_capture (go_backup),
        .i_clear   (stamp_clear_reg),
        .i_time    (i_time_date),
        .o_stamp   (tobat_stamp),
        .o_valid   (tobat_valid)
    );

    switch_stamp #(
        .KEEP_FIRST (0)
    ) u_tosup (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_capture (go_normal),
        .i_clear   (stamp_clear_reg),
        .i_time    (i_time_date),
        .o_stamp   (tosup_stamp),
        .o_valid   (tosup_valid)
    );

    // Status events; a set in the clearing cycle wins
    always @* begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~i_writedata[`ST_WIDTH-1:0];
        end
        if (cold_armed_reg && i_cold_start) begin
            status_next[`ST_TOTAL_LOSS] = 1'b1;
        end
        if (sel_level(lvl_sync, sel_reg)) begin
            status_next[`ST_BROWNOUT] = 1'b1;
        end
        // Levels taken only on a measurement request
        if (measure_reg) begin
            status_next[`ST_BAT_FIRST]  = status_next[`ST_BAT_FIRST] | bat_sync[0] | bat_sync[1];
            status_next[`ST_BAT_SECOND] = status_next[`ST_BAT_SECOND] | bat_sync[1];
        end
        if (go_backup) begin
            status_next[`ST_TO_BATTERY] = 1'b1;
        end
        if (go_normal) begin
            status_next[`ST_TO_SUPPLY] = 1'b1;
        end
    end

    // Cold start sampled once, the cycle after reset release
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            status_reg     <= {`ST_WIDTH{1'b0}};
            cold_armed_reg <= 1'b1;
            irq_reg        <= 1'b0;
        end else begin
            status_reg     <= status_next;
            cold_armed_reg <= 1'b0;
            irq_reg        <= |(status_next & mask_reg);
        end
    end

    // Pin gating; brownout never reaches the bus enable
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            scl_gated_reg     <= 1'b1;
            sda_gated_reg     <= 1'b1;
            serial_enable_reg <= 1'b0;
            battery_mode_reg  <= 1'b0;
            aux_io_enable_reg <= 1'b0;
            comp_run_reg      <= 1'b0;
        end else begin
            // Idle-high lines in backup so the bus sees nothing
            scl_gated_reg     <= in_backup ? 1'b1 : i_scl;
            sda_gated_reg     <= in_backup ? 1'b1 : i_sda;
            serial_enable_reg <= !in_backup;
            battery_mode_reg  <= in_backup;
            aux_io_enable_reg <= aux_enable_reg;
            comp_run_reg      <= !in_backup || backup_sense_reg;
        end
    end

    assign o_readdata         = readdata_reg;
    assign o_waitrequest      = waitrequest_reg;
    assign o_scl_gated        = scl_gated_reg;
    assign o_sda_gated        = sda_gated_reg;
    assign o_serial_enable    = serial_enable_reg;
    assign o_battery_mode     = battery_mode_reg;
    assign o_aux_io_enable    = aux_io_enable_reg;
    assign o_compensation_run = comp_run_reg;
    assign o_measure_pulse    = measure_reg;
    assign o_irq              = irq_reg;

endmodule // backup_power_supervisor

// ===== core/level_sync.v
// Purpose: Two-flop synchroniser for a group of comparator levels
// Assumes: Inputs are slow analog comparator results
// Notes:   First stage feeds the second stage only
module level_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input  wire             i_mclk,
    input  wire             i_sys_rst,
    // Levels
    input  wire [WIDTH-1:0] i_level,
    output wire [WIDTH-1:0] o_level
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // Two stages; reset clears both
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_level;
            sync_reg <= meta_reg;
        end
    end

    assign o_level = sync_reg;

endmodule // level_sync

// ===== core/supervisor_map.vh
// Purpose: Register offsets, fields and resets of the backup power supervisor
// Assumes: 32-bit Avalon-MM data, byte addresses, one word per register
// Notes:   Definitions only
`ifndef SUPERVISOR_MAP_VH
`define SUPERVISOR_MAP_VH

// Register byte offsets
`define OFS_STATUS       6'h00
`define OFS_MASK         6'h04
`define OFS_CONTROL      6'h08
`define OFS_MODE         6'h0C
`define OFS_TOBAT_LO     6'h10
`define OFS_TOBAT_HI     6'h14
`define OFS_TOSUP_LO     6'h18
`define OFS_TOSUP_HI     6'h1C

// Status and mask bit positions
`define ST_TOTAL_LOSS    0
`define ST_BROWNOUT      1
`define ST_BAT_FIRST     2
`define ST_BAT_SECOND    3
`define ST_TO_BATTERY    4
`define ST_TO_SUPPLY     5
`define ST_WIDTH         6

// Control bit positions
`define CT_SENSE         0
`define CT_BACKUP_SENSE  1
`define CT_STAMP_CLEAR   2
`define CT_SEL_LSB       4
`define CT_SEL_MSB       6
`define CT_AUX_ENABLE    8

// Reset values
`define RST_MASK         6'h00
`define RST_SEL          3'h0
`define RST_AUX_ENABLE   1'b1
`define RST_BACKUP_SENSE 1'b0

// Brownout levels and stamp width
`define BROWNOUT_LEVELS  6
`define STAMP_WIDTH      40

`endif

// ===== core/switch_stamp.v
// Purpose: Time and date stamp of one switchover direction
// Assumes: Capture is a one-cycle pulse
// Notes:   KEEP_FIRST holds the earliest event, else the latest wins
`include "supervisor_map.vh"
module switch_stamp #(
    parameter KEEP_FIRST = 0
) (
    // Clock and reset
    input  wire                    i_mclk,
    input  wire                    i_sys_rst,
    // Control
    input  wire                    i_capture,
    input  wire                    i_clear,
    input  wire [`STAMP_WIDTH-1:0] i_time,
    // Stamp
    output wire [`STAMP_WIDTH-1:0] o_stamp,
    output wire                    o_valid
);

    reg [`STAMP_WIDTH-1:0] stamp_reg;
    reg                    valid_reg;
    wire                   take;

    // A held first stamp refuses later captures
    assign take = i_capture && !(KEEP_FIRST != 0 && valid_reg);

    // A taken capture beats clear in the same cycle; a capture refused by a held first stamp is lost
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            stamp_reg <= {`STAMP_WIDTH{1'b0}};
            valid_reg <= 1'b0;
        end else if (take) begin
            stamp_reg <= i_time;
            valid_reg <= 1'b1;
        end else if (i_clear) begin
            stamp_reg <= {`STAMP_WIDTH{1'b0}};
            valid_reg <= 1'b0;
        end
    end

    assign o_stamp = stamp_reg;
    assign o_valid = valid_reg;

endmodule // switch_stamp

// ===== tb/supervisor_assertions.sv
// Purpose: Port checks of the backup power supervisor
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
`include "supervisor_map.vh"
module supervisor_assertions (
    // Clock, reset and register bus
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic [5:0]  i_address,
    input wire logic        i_write,
    input wire logic [31:0] i_writedata,
    input wire logic        o_waitrequest,
    // Supply comparators and serial lines
    input wire logic        i_vdd_below_bat_hys,
    input wire logic        i_vdd_below_trip,
    input wire logic        i_vdd_above_bat_hys,
    input wire logic        i_vdd_above_trip_hys,
    input wire logic        i_scl,
    input wire logic        o_scl_gated,
    input wire logic        o_sda_gated,
    // Mode and side outputs
    input wire logic        o_serial_enable,
    input wire logic        o_battery_mode,
    input wire logic        o_aux_io_enable,
    input wire logic        o_compensation_run,
    input wire logic        o_measure_pulse
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // Decoded conditions; writes may land one or two edges before their effect
    wire both_low = i_vdd_below_bat_hys && i_vdd_below_trip;
    wire any_high = i_vdd_above_bat_hys || i_vdd_above_trip_hys;
    wire ctl_wr   = i_write && !o_waitrequest && i_address == `OFS_CONTROL;
    wire sense_wr = ctl_wr && i_writedata[`CT_SENSE];
    wire aux_off  = ctl_wr && !i_writedata[`CT_AUX_ENABLE];
    sequence s_low_held;
        both_low [*6];
    endsequence
    sequence s_high_held;
        any_high [*6];
    endsequence
    property p_enter_cause;
        $rose(o_battery_mode) |-> $past(both_low, 4);
    endproperty
    a_enter_cause: assert property (p_enter_cause) else $error("backup without both conditions");
    property p_enter_time;
        s_low_held |-> o_battery_mode;
    endproperty
    a_enter_time: assert property (p_enter_time) else $error("backup not entered");
    property p_leave_time;
        s_high_held |-> !o_battery_mode && o_serial_enable;
    endproperty
    a_leave_time: assert property (p_leave_time) else $error("backup not left");
    property p_bus_off;
        o_battery_mode |-> o_scl_gated && o_sda_gated && !o_serial_enable;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("serial bus live in backup");
    property p_bus_on;
        o_serial_enable |-> o_scl_gated == $past(i_scl);
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("serial bus blocked in normal mode");
    property p_comp_run;
        o_serial_enable |-> o_compensation_run;
    endproperty
    a_comp_run: assert property (p_comp_run) else $error("compensation off in normal mode");
    property p_aux_fall;
        $fell(o_aux_io_enable) |-> $past(aux_off) || $past(aux_off, 2);
    endproperty
    a_aux_fall: assert property (p_aux_fall) else $error("aux pins disabled without write");
    property p_measure;
        o_measure_pulse |-> !o_battery_mode && ($past(sense_wr) || $past(sense_wr, 2)) ##1 !o_measure_pulse;
    endproperty
    a_measure: assert property (p_measure) else $error("bad battery measurement pulse");
endmodule // supervisor_assertions

bind backup_power_supervisor supervisor_assertions u_chk (.*);

// ===== tb/supply_model.sv
// Purpose: Behavioural supply and battery comparators
// Assumes: Supply and battery given in millivolts
// Notes:   Thresholds are plain defaults; brownout levels rise in equal steps
module supply_model #(
    parameter int BAT_HYS  = 32'h32,
    parameter int TRIP     = 32'h898,
    parameter int TRIP_HYS = 32'h1E,
    parameter int BAT_NOM  = 32'hBB8,
    parameter int LVL_BASE = 32'h8FC,
    parameter int LVL_STEP = 32'h64
) (
    // Supply and battery in millivolts
    input  wire logic [15:0] i_vdd_mv,
    input  wire logic [15:0] i_bat_mv,
    // Supply comparators
    output wire logic        o_below_bat_hys,
    output wire logic        o_below_trip,
    output wire logic        o_above_bat_hys,
    output wire logic        o_above_trip_hys,
    output wire logic [5:0]  o_below_level,
    // Battery comparators
    output wire logic        o_bat_below_85,
    output wire logic        o_bat_below_75
);
    // Ideal comparators; hysteresis bands keep enter and leave apart
    assign o_below_bat_hys  = int'(i_vdd_mv) < int'(i_bat_mv) - BAT_HYS;
    assign o_below_trip     = int'(i_vdd_mv) < TRIP;
    assign o_above_bat_hys  = int'(i_vdd_mv) > int'(i_bat_mv) + BAT_HYS;
    assign o_above_trip_hys = int'(i_vdd_mv) > TRIP + TRIP_HYS;
    assign o_bat_below_85   = int'(i_bat_mv) * 32'h64 < BAT_NOM * 32'h55;
    assign o_bat_below_75   = int'(i_bat_mv) * 32'h64 < BAT_NOM * 32'h4B;
    // One comparator per brownout level
    for (genvar k = 0; k < $bits(o_below_level); k++) begin : g_lvl
        assign o_below_level[k] = int'(i_vdd_mv) < LVL_BASE + k * LVL_STEP;
    end
endmodule // supply_model

// ===== tb/test_backup_power_supervisor.sv
// Purpose: Self-checking bench of the backup power supervisor
// Assumes: Comparators come from supply_model
// Notes:   Supply steps are held past the synchroniser delay
`include "supervisor_map.vh"
module test_backup_power_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    // Design inputs, all set at time zero
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [5:0]  i_address = 6'h00;
    logic        i_read = 1'b0;
    logic        i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic        i_cold_start = 1'b1;
    logic [39:0] i_time_date = 40'h0;
    logic        i_scl = 1'b0;
    logic        i_sda = 1'b1;
    logic [15:0] vdd_mv = 16'h0CE4;
    logic [15:0] bat_mv = 16'h0BB8;
    // Outputs, comparator levels and bookkeeping
    wire [31:0] o_readdata;
    wire        o_waitrequest, o_scl_gated, o_sda_gated, o_serial_enable, o_battery_mode;
    wire        o_aux_io_enable, o_compensation_run, o_measure_pulse, o_irq;
    wire        lo_bh, lo_tr, hi_bh, hi_th, b85, b75;
    wire [5:0]  lo_lvl;
    int         err_total = 0;
    int         checks_done = 0;
    int         cycles = 0;
    logic [31:0] rdq;
    logic [15:0] bat_tab [3] = '{16'h0A8C, 16'h0960, 16'h0834};
    logic [31:0] st_tab [3] = '{32'h0, 32'h4, 32'hC};

    supply_model u_sup (.i_vdd_mv(vdd_mv), .i_bat_mv(bat_mv), .o_below_bat_hys(lo_bh), .o_below_trip(lo_tr),
        .o_above_bat_hys(hi_bh), .o_above_trip_hys(hi_th), .o_below_level(lo_lvl), .o_bat_below_85(b85),
        .o_bat_below_75(b75));
    backup_power_supervisor u_dut (.*, .i_vdd_below_bat_hys(lo_bh), .i_vdd_below_trip(lo_tr),
        .i_vdd_above_bat_hys(hi_bh), .i_vdd_above_trip_hys(hi_th), .i_vdd_below_level(lo_lvl),
        .i_bat_below_85(b85), .i_bat_below_75(b75));

    // Clock, toggling serial lines and run limit
    always #2 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        i_scl <= ~i_scl;
        i_sda <= i_scl;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask

    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= d;
        i_read <= !w;
        i_write <= w;
        do begin
            @(posedge i_mclk);
        end while (o_waitrequest !== 1'b0);
        rdq = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdq, e);
    endtask

    // Control word with aux pins on
    function automatic logic [31:0] ctlw(input logic [2:0] sel, input logic bs);
        return {23'h0, 1'b1, 1'b0, sel, 2'b00, bs, 1'b0};
    endfunction

    // Step the supply, stamp time {5{t}}, then look at mode and bus gating
    task automatic supply(input logic [15:0] v, input logic [15:0] b, input logic [7:0] t, input logic m);
        i_time_date <= {5{t}};
        vdd_mv <= v;
        bat_mv <= b;
        tick(8);
        chk({o_battery_mode, o_serial_enable}, {m, !m});
        if (m) chk({o_scl_gated, o_sda_gated}, 2'b11);
    endtask

    initial begin
        tick(8);
        i_sys_rst <= 1'b0;
        tick(2);
        i_cold_start <= 1'b0;
        // Reset values, unmapped space, interrupt
        rd(`OFS_STATUS, 32'h1);
        rd(`OFS_MASK, 32'h0);
        rd(`OFS_CONTROL, 32'h100);
        bus(1'b1, 6'h24, 32'hFFFFFFFF);
        rd(6'h24, 32'h0);
        bus(1'b1, `OFS_MASK, 32'h3F);
        tick(3);
        chk(o_irq, 1'b1);
        bus(1'b1, `OFS_STATUS, 32'h1);
        tick(3);
        chk(o_irq, 1'b0);
        bus(1'b1, `OFS_MASK, 32'h0);
        $display("reset test done");
        // Brownout: supply under level k, above level k-1
        for (int k = 0; k < 6; k++) begin
            vdd_mv <= 16'h08CA + 16'h0064 * k;
            tick(4);
            bus(1'b1, `OFS_STATUS, 32'h3F);
            tick(4);
            if (k > 0) rd(`OFS_STATUS, 32'h0);
            bus(1'b1, `OFS_CONTROL, ctlw(k, 1'b0));
            tick(4);
            rd(`OFS_STATUS, 32'h2);
            chk(o_serial_enable, 1'b1);
        end
        bus(1'b1, `OFS_CONTROL, ctlw(3'h7, 1'b0));
        tick(4);
        bus(1'b1, `OFS_STATUS, 32'h3F);
        tick(4);
        rd(`OFS_STATUS, 32'h0);
        vdd_mv <= 16'h0CE4;
        bus(1'b1, `OFS_CONTROL, ctlw(3'h0, 1'b0));
        $display("brownout test done");
        // Battery grading after a measurement request
        for (int i = 0; i < 3; i++) begin
            bat_mv <= bat_tab[i];
            tick(4);
            bus(1'b1, `OFS_STATUS, 32'h3F);
            bus(1'b1, `OFS_CONTROL, ctlw(3'h0, 1'b0) | 32'h1);
            tick(4);
            rd(`OFS_STATUS, st_tab[i]);
        end
        bat_mv <= 16'h0BB8;
        tick(4);
        $display("battery test done");
        // Switchovers, stamps, interrupt and stamp clear
        bus(1'b1, `OFS_STATUS, 32'h3F);
        bus(1'b1, `OFS_MASK, 32'h10);
        supply(16'h0834, 16'h0BB8, 8'hA1, 1'b1);
        chk(o_compensation_run, 1'b0);
        chk(o_irq, 1'b1);
        supply(16'h08BE, 16'h0BB8, 8'hA2, 1'b0);
        bus(1'b1, `OFS_CONTROL, ctlw(3'h0, 1'b1));
        supply(16'h0834, 16'h0BB8, 8'hA3, 1'b1);
        chk(o_compensation_run, 1'b1);
        supply(16'h0CE4, 16'h0BB8, 8'hA4, 1'b0);
        rd(`OFS_TOBAT_LO, 32'hA1A1A1A1);
        rd(`OFS_TOBAT_HI, 32'hA1);
        rd(`OFS_TOSUP_LO, 32'hA4A4A4A4);
        rd(`OFS_TOSUP_HI, 32'hA4);
        rd(`OFS_MODE, 32'h6);
        bus(1'b1, `OFS_MASK, 32'h0);
        tick(3);
        chk(o_irq, 1'b0);
        bus(1'b1, `OFS_MASK, 32'h30);
        bus(1'b1, `OFS_STATUS, 32'h30);
        tick(3);
        chk(o_irq, 1'b0);
        bus(1'b1, `OFS_CONTROL, ctlw(3'h0, 1'b1) | 32'h4);
        tick(3);
        rd(`OFS_TOBAT_HI, 32'h0);
        rd(`OFS_TOSUP_LO, 32'h0);
        rd(`OFS_MODE, 32'h0);
        supply(16'h06A4, 16'h0708, 8'hA5, 1'b1);
        bus(1'b1, `OFS_CONTROL, ctlw(3'h0, 1'b1) | 32'h1);
        rd(`OFS_STATUS, 32'h12);
        supply(16'h076C, 16'h0708, 8'hA6, 1'b0);
        supply(16'h0B54, 16'h0BB8, 8'hA7, 1'b0);
        supply(16'h0834, 16'h07D0, 8'hA8, 1'b0);
        rd(`OFS_TOBAT_LO, 32'hA5A5A5A5);
        $display("switchover test done");
        // Aux pins follow their control bit
        bus(1'b1, `OFS_CONTROL, 32'h0);
        tick(3);
        chk(o_aux_io_enable, 1'b0);
        bus(1'b1, `OFS_CONTROL, 32'h100);
        tick(3);
        chk(o_aux_io_enable, 1'b1);
        $display("aux test done");
        give_verdict();
    end
endmodule // test_backup_power_supervisor
